// ---- pkg/pfbi_pkg.sv ----
// package for the parallel flash host controller
// assumes one 100 MHz clock and an AHB-Lite register port
package pfbi_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;

  localparam int CTRL_WORD_BIT = 0;
  localparam int CTRL_BYP_BIT = 1;
  localparam int CTRL_RST_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;

  localparam int STAT_SEQ_BIT = 0;
  localparam int STAT_DEV_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_REF_BIT = 3;
  localparam int DQ_TIMEOUT_BIT = 5;

  // ----------------------------------------------------------------
  // command sequence words (arbitrary values, set for the part)
  // ----------------------------------------------------------------
  localparam logic [18:0] UNL1_A = 19'h00001;
  localparam logic [18:0] UNL2_A = 19'h00002;
  localparam logic [15:0] UNL1_D = 16'h0001;
  localparam logic [15:0] UNL2_D = 16'h0002;
  localparam logic [15:0] PROG_D = 16'h0003;
  localparam logic [15:0] ERS_D = 16'h0004;
  localparam logic [15:0] SECT_D = 16'h0005;
  localparam logic [15:0] SUSP_D = 16'h0006;
  localparam logic [15:0] RESUME_D = 16'h0007;
  localparam logic [15:0] SWRST_D = 16'h0008;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int T_BUSY_NS = 90;
  localparam int SYNC_CYC = 2;
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RD_CYC =
    8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [7:0] BUSY_CYC =
    8'((T_BUSY_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_PROG, OP_ERASE, OP_SUSP, OP_RESUME, OP_SWRST
  } pfbi_op_t;

  typedef struct packed {
    logic we;
    logic [18:0] addr;
    logic [15:0] data;
  } pfbi_cyc_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [17:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
  } pfbi_bus_t;

  localparam pfbi_bus_t BUS_IDLE = '{1'b1, 1'b1, 1'b1, 18'h0, 16'h0, 16'h0};

endpackage

// ---- src/pfbi_ctrl.sv ----
// host controller for a parallel nor flash, registers over ahb-lite
// assumes a single ahb-lite master and the flash pins on flash_bus
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
module pfbi_ctrl import pfbi_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output pfbi_bus_t flash_bus,
  output logic flash_reset_n,
  output logic flash_byte_n,
  input wire logic [15:0] flash_dq_in,
  input wire logic busy_n_out
);

  typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT, SQ_POLL} pfbi_sq_t;

  // ----------------------------------------------------------------
  // sequence tables
  // ----------------------------------------------------------------
  function automatic logic [2:0] seq_len(pfbi_op_t op, logic byp);
    unique case (op)
      OP_PROG: seq_len = byp ? 3'd2 : 3'd4;
      OP_ERASE: seq_len = 3'd6;
      default: seq_len = 3'd1;
    endcase
  endfunction

  function automatic pfbi_cyc_t seq_step(pfbi_op_t op, logic [2:0] idx,
      logic byp, logic [18:0] a, logic [15:0] d);
    logic [2:0] k;
    k = (op == OP_PROG && byp) ? idx + 3'd2 : idx;
    seq_step = '{1'b1, a, d};
    unique case (op)
      OP_READ: seq_step.we = 1'b0;
      OP_PROG: begin
        unique case (k)
          3'd0: seq_step = '{1'b1, UNL1_A, UNL1_D};
          3'd1: seq_step = '{1'b1, UNL2_A, UNL2_D};
          3'd2: seq_step = '{1'b1, UNL1_A, PROG_D};
          default: seq_step = '{1'b1, a, d};
        endcase
      end
      OP_ERASE: begin
        unique case (idx)
          3'd0, 3'd3: seq_step = '{1'b1, UNL1_A, UNL1_D};
          3'd1, 3'd4: seq_step = '{1'b1, UNL2_A, UNL2_D};
          3'd2: seq_step = '{1'b1, UNL1_A, ERS_D};
          default: seq_step = '{1'b1, a, SECT_D};
        endcase
      end
      OP_SUSP: seq_step.data = SUSP_D;
      OP_RESUME: seq_step.data = RESUME_D;
      OP_SWRST: seq_step.data = SWRST_D;
      default: seq_step.we = 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic dph_wr_r;
  logic [7:0] dph_addr_r;
  logic [2:0] ctrl_r;
  logic [18:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic err_r;
  logic ref_r;
  logic rst_pin_r;
  logic busy_m_r;
  logic busy_s_r;
  logic [2:0] wr_cnt_r;
  pfbi_sq_t sq_r;
  pfbi_sq_t sq_nxt;
  pfbi_op_t op_r;
  logic [2:0] idx_r;
  logic [7:0] cnt_r;
  logic byp_r;

  wire aph = hsel && htrans[1] && hready;
  wire wr_ev = dph_wr_r;
  wire cmd_wr = wr_ev && dph_addr_r == REG_CMD;
  wire stat_wr = wr_ev && dph_addr_r == REG_STAT;
  wire rst_on = ctrl_r[CTRL_RST_BIT] || !rst_pin_r;
  wire cmd_ok = cmd_wr && sq_r == SQ_IDLE && !rst_on;
  wire [31:0] stat_val = {28'h0, ref_r, err_r, !busy_s_r, sq_r != SQ_IDLE};
  wire cyc_ready;
  wire cyc_done;
  wire [15:0] cyc_rdata;
  wire cyc_start = sq_r == SQ_ISSUE && cyc_ready;
  wire last_step = idx_r == seq_len(op_r, byp_r) - 3'd1;
  wire long_op = op_r == OP_PROG || op_r == OP_ERASE;
  wire dq5_hit = cyc_done && op_r == OP_READ && !busy_s_r &&
    cyc_rdata[DQ_TIMEOUT_BIT];
  wire pfbi_cyc_t cyc_req =
    seq_step(op_r, idx_r, byp_r, addr_r, wdata_r);

  logic [31:0] rd_mux;
  always_comb begin
    unique case (haddr[7:0])
      REG_CTRL: rd_mux = {29'h0, ctrl_r};
      REG_ADDR: rd_mux = {13'h0, addr_r};
      REG_WDATA: rd_mux = {16'h0, wdata_r};
      REG_STAT: rd_mux = stat_val;
      REG_RDATA: rd_mux = {16'h0, rdata_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // width select pin follows the mode bit
  assign flash_byte_n = ctrl_r[CTRL_WORD_BIT];
  assign flash_reset_n = rst_pin_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      dph_wr_r <= aph && hwrite;
      dph_addr_r <= haddr[7:0];
      if (aph && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
      addr_r <= 19'h00000;
      wdata_r <= 16'h0000;
      rst_pin_r <= 1'b1;
    end else begin
      if (wr_ev && dph_addr_r == REG_CTRL) ctrl_r <= hwdata[2:0];
      if (wr_ev && dph_addr_r == REG_ADDR) addr_r <= hwdata[18:0];
      if (wr_ev && dph_addr_r == REG_WDATA) wdata_r <= hwdata[15:0];
      rst_pin_r <= !ctrl_r[CTRL_RST_BIT];
    end
  end

  // sticky flags, a new event wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_r <= 1'b0;
      ref_r <= 1'b0;
    end else begin
      if (dq5_hit) err_r <= 1'b1;
      else if (stat_wr && hwdata[STAT_ERR_BIT]) err_r <= 1'b0;
      if (cmd_wr && !cmd_ok) ref_r <= 1'b1;
      else if (stat_wr && hwdata[STAT_REF_BIT]) ref_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_comb begin
    sq_nxt = sq_r;
    unique case (sq_r)
      SQ_IDLE: if (cmd_ok) sq_nxt = SQ_ISSUE;
      SQ_ISSUE: if (cyc_ready) sq_nxt = SQ_WAIT;
      SQ_WAIT: if (cyc_done) begin
        if (!last_step) sq_nxt = SQ_ISSUE;
        else sq_nxt = long_op ? SQ_POLL : SQ_IDLE;
      end
      SQ_POLL: if (cnt_r == 8'h00 && busy_s_r) sq_nxt = SQ_IDLE;
    endcase
    if (rst_on) sq_nxt = SQ_IDLE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sq_r <= SQ_IDLE;
      op_r <= OP_READ;
      byp_r <= 1'b0;
      idx_r <= 3'd0;
      cnt_r <= 8'h00;
      rdata_r <= 16'h0000;
      busy_m_r <= 1'b1;
      busy_s_r <= 1'b1;
      wr_cnt_r <= 3'd0;
    end else begin
      sq_r <= sq_nxt;
      busy_m_r <= busy_n_out;
      busy_s_r <= busy_m_r;
      if (cmd_ok) begin
        op_r <= pfbi_op_t'(hwdata[2:0]);
        byp_r <= ctrl_r[CTRL_BYP_BIT];
        idx_r <= 3'd0;
        wr_cnt_r <= 3'd0;
      end
      if ($fell(flash_bus.we_n)) wr_cnt_r <= wr_cnt_r + 3'd1;
      if (sq_r == SQ_WAIT && cyc_done) begin
        idx_r <= idx_r + 3'd1;
        cnt_r <= BUSY_CYC;
        if (op_r == OP_READ) rdata_r <= cyc_rdata;
      end
      if (sq_r == SQ_POLL && cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
  end

  pfbi_cyc u_cyc (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(cyc_start),
    .abort(rst_on),
    .req(cyc_req),
    .word_mode(ctrl_r[CTRL_WORD_BIT]),
    .dq_in(flash_dq_in),
    .ready(cyc_ready),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .bus(flash_bus)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_enter_poll;
    sq_r == SQ_WAIT && sq_nxt == SQ_POLL;
  endsequence

  property p_prog_four;
    @(posedge hclk) disable iff (!hresetn)
      s_enter_poll and op_r == OP_PROG && !byp_r |-> wr_cnt_r == 3'd4;
  endproperty
  a_prog_four: assert property (p_prog_four)
    else $error("full program did not take four writes");

  property p_prog_two;
    @(posedge hclk) disable iff (!hresetn)
      s_enter_poll and op_r == OP_PROG && byp_r |-> wr_cnt_r == 3'd2;
  endproperty
  a_prog_two: assert property (p_prog_two)
    else $error("bypass program did not take two writes");

  property p_reset_standby;
    @(posedge hclk) disable iff (!hresetn)
      !flash_reset_n |-> flash_bus.ce_n && sq_r == SQ_IDLE;
  endproperty
  a_reset_standby: assert property (p_reset_standby)
    else $error("flash selected while reset pin low");

  property p_poll_hold;
    @(posedge hclk) disable iff (!hresetn)
      $rose(sq_r == SQ_POLL) && !rst_on |->
        (sq_r == SQ_POLL || rst_on) [*8];
  endproperty
  a_poll_hold: assert property (p_poll_hold)
    else $error("left busy wait before busy delay");

  property p_dq5_flag;
    @(posedge hclk) disable iff (!hresetn)
      dq5_hit |=> err_r ##1 (err_r || $past(stat_wr));
  endproperty
  a_dq5_flag: assert property (p_dq5_flag)
    else $error("status bit 5 not flagged");

endmodule

// ---- src/pfbi_cyc.sv ----
// one read or write cycle on the flash pins
// assumes data pins arrive asynchronously and are synchronised here
`timescale 1ns/1ns
module pfbi_cyc import pfbi_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic abort,
  input wire pfbi_cyc_t req,
  input wire logic word_mode,
  input wire logic [15:0] dq_in,
  output logic ready,
  output logic done,
  output logic [15:0] rdata,
  output pfbi_bus_t bus
);

  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} pfbi_cy_t;

  pfbi_cy_t cy_r;
  logic [7:0] cnt_r;
  logic we_r;
  logic word_r;
  logic [15:0] dq_m_r;
  logic [15:0] dq_s_r;
  pfbi_bus_t bus_r;

  wire [15:0] oe_wr = word_mode ? 16'hffff : 16'h80ff;
  wire [15:0] oe_rd = word_mode ? 16'h0000 : 16'h8000;
  wire [17:0] pin_addr = word_mode ? req.addr[17:0] : req.addr[18:1];
  wire [15:0] pin_data = word_mode ? req.data :
    {req.addr[0], 7'h00, req.data[7:0]};
  wire [15:0] rd_val = word_r ? dq_s_r : {8'h00, dq_s_r[7:0]};

  assign ready = (cy_r == CY_IDLE);
  assign bus = bus_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_m_r <= 16'h0000;
      dq_s_r <= 16'h0000;
    end else begin
      dq_m_r <= dq_in;
      dq_s_r <= dq_m_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cy_r <= CY_IDLE;
      cnt_r <= 8'h00;
      we_r <= 1'b0;
      word_r <= 1'b1;
      done <= 1'b0;
      rdata <= 16'h0000;
      bus_r <= BUS_IDLE;
    end else begin
      done <= 1'b0;
      if (abort) begin
        cy_r <= CY_IDLE;
        bus_r <= BUS_IDLE;
      end else begin
        unique case (cy_r)
          CY_IDLE: if (start) begin
            cy_r <= CY_SETUP;
            we_r <= req.we;
            word_r <= word_mode;
            bus_r.ce_n <= 1'b0;
            bus_r.addr <= pin_addr;
            // byte mode drives the low address bit on dq15
            bus_r.dq_out <= pin_data;
            // upper byte lanes dq8 to dq14 stay undriven in byte mode, dq15 is driven
            bus_r.dq_oe <= req.we ? oe_wr : oe_rd;
          end
          CY_SETUP: begin
            cy_r <= CY_PULSE;
            cnt_r <= we_r ? WP_CYC : RD_CYC;
            // only one strobe at a time, with chip select low
            bus_r.we_n <= !we_r;
            bus_r.oe_n <= we_r;
          end
          CY_PULSE: begin
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
              cy_r <= CY_HOLD;
              bus_r.we_n <= 1'b1;
              bus_r.oe_n <= 1'b1;
              if (!we_r) begin
                rdata <= rd_val;
              end
            end
          end
          CY_HOLD: begin
            cy_r <= CY_IDLE;
            done <= 1'b1;
            // release the bus with chip select
            bus_r <= BUS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_we_pulse;
    (bus.we_n == 1'b0) [*4] ##1 bus.we_n;
  endsequence

  property p_we_width;
    @(posedge hclk) disable iff (!hresetn)
      $fell(bus.we_n) && !abort |-> s_we_pulse or ##[0:3] abort;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write pulse width wrong");

  property p_write_qual;
    @(posedge hclk) disable iff (!hresetn)
      !bus.we_n |-> !bus.ce_n && bus.oe_n && bus.dq_oe[0];
  endproperty
  a_write_qual: assert property (p_write_qual)
    else $error("write strobe without ce or with oe");

  property p_read_qual;
    @(posedge hclk) disable iff (!hresetn)
      !bus.oe_n |-> !bus.ce_n && bus.we_n && !bus.dq_oe[0];
  endproperty
  a_read_qual: assert property (p_read_qual)
    else $error("read strobe without ce or with we or drive");

  property p_byte_lanes;
    @(posedge hclk) disable iff (!hresetn)
      !bus.ce_n && !word_r |-> bus.dq_oe[14:8] == 7'h00 && bus.dq_oe[15];
  endproperty
  a_byte_lanes: assert property (p_byte_lanes)
    else $error("byte mode lanes driven wrongly");

  property p_float_idle;
    @(posedge hclk) disable iff (!hresetn)
      bus.ce_n |-> bus.dq_oe == 16'h0000 && bus.we_n && bus.oe_n;
  endproperty
  a_float_idle: assert property (p_float_idle)
    else $error("bus driven with chip select high");

endmodule

// ---- verification/pfbi_flash_model.sv ----
// behavioural model of the parallel nor flash seen by the controller
// assumes the controller drives the pins; dq has no pull, busy has a pull-up
`timescale 1ns/1ns
module pfbi_flash_model import pfbi_pkg::*; #(
  parameter int PROG_NS = 500,
  parameter int ERASE_NS = 3000
) (
  input wire pfbi_bus_t bus,
  input wire logic reset_n,
  input wire logic byte_n,
  output logic [15:0] dq_lvl,
  output logic busy_n
);
  // ------------------------------------------------------------
  // array, command decode and status
  // ------------------------------------------------------------
  logic [15:0] mem [int];
  logic [17:0] wa;
  logic [15:0] rd_val, junk, pdat;
  logic [5:0] ers_sec;
  logic drv, prg_arm, ers_arm, ers_pend, tog, susp, lowv;
  int busy_left, cnt, last_len, n_bad;
  wire rd = !bus.ce_n && !bus.oe_n && bus.we_n && reset_n;
  function automatic logic [15:0] peek(input int i);
    return mem.exists(i) ? mem[i] : 16'hffff;
  endfunction
  task automatic take(input logic [17:0] a, input logic [15:0] d);
    logic [15:0] w;
    logic [15:0] dc;
    // byte mode carries the low address bit on dq15, not data
    dc = byte_n ? d : {8'h00, d[7:0]};
    if (lowv) return;
    cnt++;
    if (prg_arm) begin
      w = byte_n ? d : (d[15] ? {d[7:0], 8'hff} : {8'hff, d[7:0]});
      mem[int'(a)] = peek(int'(a)) & w;
      pdat = w;
      prg_arm = 1'b0;
      last_len = cnt;
      cnt = 0;
      busy_left = PROG_NS / 10;
    end else if (ers_arm && dc == SECT_D) begin
      {ers_sec, ers_pend, ers_arm, pdat} = {a[17:12], 2'b10, 16'h0};
      last_len = cnt;
      cnt = 0;
      busy_left = ERASE_NS / 10;
    end else if (dc == PROG_D) prg_arm = 1'b1;
    else if (dc == ERS_D) ers_arm = 1'b1;
    else if (dc == SUSP_D && ers_pend) susp = 1'b1;
    else if (dc == RESUME_D) susp = 1'b0;
    else if (dc == SWRST_D) begin
      cnt = 0;
      {prg_arm, ers_arm} = 2'b00;
    end
  endtask
  initial begin
    {junk, drv, prg_arm, ers_arm, ers_pend, tog} = {16'h5a5a, 5'h0};
    {susp, lowv} = 2'b00;
    busy_left = 0;
    cnt = 0;
    last_len = 0;
    n_bad = 0;
  end
  always #10 junk = ~junk;
  assign busy_n = (busy_left > 0 && !susp) ? 1'b0 : 1'b1;
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      dq_lvl[b] = bus.dq_oe[b] ? bus.dq_out[b] :
        (drv && (byte_n || b < 8)) ? rd_val[b] : junk[b];
    end
  end
  always @(negedge bus.we_n) begin
    wa = bus.addr;
    if (bus.ce_n || !bus.oe_n) n_bad++;
    if (!byte_n && bus.dq_oe[14:8] != 7'h0) n_bad++;
  end
  always @(posedge bus.we_n) begin
    if (!bus.ce_n && reset_n) take(wa, bus.dq_out);
  end
  always @(negedge bus.oe_n) begin
    drv = 1'b0;
    #(T_ACC_NS);
    if (rd) begin
      if ((bus.dq_oe & (byte_n ? 16'hffff : 16'h7fff)) != 16'h0) n_bad++;
      if (busy_left > 0) begin
        rd_val = {8'h0, ~pdat[7], tog, 6'h0};
        tog = ~tog;
      end else begin
        rd_val = peek(int'(bus.addr));
        if (!byte_n && bus.dq_out[15]) rd_val[7:0] = rd_val[15:8];
      end
      drv = 1'b1;
    end
  end
  always @(posedge bus.oe_n or posedge bus.ce_n or negedge reset_n) begin
    drv = 1'b0;
  end
  always @(negedge reset_n) begin
    {ers_pend, prg_arm, ers_arm, susp} = 4'h0;
    busy_left = 0;
    cnt = 0;
  end
  always #10 begin
    if (reset_n && !susp && busy_left > 0) begin
      busy_left--;
      if (busy_left == 0 && ers_pend) begin
        foreach (mem[k]) if (k[17:12] == ers_sec) mem[k] = 16'hffff;
        ers_pend = 1'b0;
      end
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the flash host controller
// assumes one ahb-lite master (this bench) and the flash model on the pins
`timescale 1ns/1ns
module tb_top import pfbi_pkg::*; ();
  // ------------------------------------------------------------
  // signals, instances and bus tasks
  // ------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, flash_reset_n, flash_byte_n, busy_n;
  logic hreadyout, hresp, seen_busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [15:0] dq_lvl;
  pfbi_bus_t flash_bus;
  int n_errors, check_count;
  pfbi_ctrl pfbi_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .flash_bus(flash_bus),
    .flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n),
    .flash_dq_in(dq_lvl), .busy_n_out(busy_n));
  pfbi_flash_model pfbi_flash_model_i (.bus(flash_bus),
    .reset_n(flash_reset_n), .byte_n(flash_byte_n), .dq_lvl(dq_lvl),
    .busy_n(busy_n));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_sim;
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'b10, wr};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0);
  endtask
  task wait_idle;
    for (int n = 0; n < 600; n++) begin
      rd(REG_STAT);
      if (rv[STAT_DEV_BIT] === 1'b1) seen_busy = 1'b1;
      if (rv[STAT_SEQ_BIT] === 1'b0) break;
    end
  endtask
  task access(input logic [2:0] op, input logic [18:0] a, input logic [15:0] d);
    wr(REG_ADDR, {13'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, {29'h0, op});
    wait_idle();
  endtask
  task read_chk(input string what, input logic [18:0] a, input logic [15:0] m,
                input logic [15:0] exp);
    access(3'h0, a, 16'h0);
    rd(REG_RDATA);
    chk(what, {16'h0, exp}, rv & {16'h0, m});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    rd(REG_CTRL);
    chk("ctrl", 32'h1, rv);
    rd(REG_STAT);
    chk("status", 32'h0, rv);
    chk("reset pin", 32'h1, {31'h0, flash_reset_n});
    chk("chip select", 32'h1, {31'h0, flash_bus.ce_n});
    wr(8'h20, 32'hffffffff);
    rd(8'h20);
    chk("unmapped", 32'h0, rv);
  endtask
  task t_word_prog;
    seen_busy = 1'b0;
    access(3'h2, 19'h12345, 16'ha55a);
    chk("program writes", 32'h4, 32'(pfbi_flash_model_i.last_len));
    chk("busy seen", 32'h1, {31'h0, seen_busy});
    read_chk("word read", 19'h12345, 16'hffff, 16'ha55a);
    wr(REG_ADDR, 32'h12346);
    wr(REG_WDATA, 32'h0ff0);
    wr(REG_CMD, 32'h2);
    wr(REG_CMD, 32'h2);
    rd(REG_STAT);
    chk("refused", 32'h1, {31'h0, rv[STAT_REF_BIT]});
    wait_idle();
    wr(REG_STAT, 32'h8);
    rd(REG_STAT);
    chk("refused clear", 32'h0, {31'h0, rv[STAT_REF_BIT]});
    chk("program writes", 32'h4, 32'(pfbi_flash_model_i.last_len));
    read_chk("second word", 19'h12346, 16'hffff, 16'h0ff0);
  endtask
  task t_byte;
    wr(REG_CTRL, 32'h0);
    rd(REG_CTRL);
    chk("width pin", 32'h0, {31'h0, flash_byte_n});
    access(3'h2, 19'h00011, 16'h003c);
    read_chk("odd byte", 19'h00011, 16'h00ff, 16'h003c);
    read_chk("even byte", 19'h00010, 16'h00ff, 16'h00ff);
    wr(REG_CTRL, 32'h1);
  endtask
  task t_bypass;
    wr(REG_CTRL, 32'h3);
    access(3'h2, 19'h00200, 16'h1234);
    chk("bypass writes", 32'h2, 32'(pfbi_flash_model_i.last_len));
    wr(REG_CTRL, 32'h1);
    read_chk("bypass word", 19'h00200, 16'hffff, 16'h1234);
  endtask
  task t_erase;
    access(3'h3, 19'h12000, 16'h0);
    chk("erase writes", 32'h6, 32'(pfbi_flash_model_i.last_len));
    read_chk("erased word", 19'h12345, 16'hffff, 16'hffff);
    read_chk("kept word", 19'h00200, 16'hffff, 16'h1234);
  endtask
  task t_hw_reset;
    wr(REG_ADDR, 32'h00200);
    wr(REG_CMD, 32'h3);
    repeat (30) rd(REG_STAT);
    wr(REG_CTRL, 32'h5);
    rd(REG_CTRL);
    chk("reset pin low", 32'h0, {31'h0, flash_reset_n});
    chk("busy released", 32'h1, {31'h0, busy_n});
    wr(REG_CMD, 32'h2);
    rd(REG_STAT);
    chk("refused in reset", 32'h1, {31'h0, rv[STAT_REF_BIT]});
    wr(REG_CTRL, 32'h1);
    wr(REG_STAT, 32'hc);
    wait_idle();
    read_chk("after reset", 19'h00200, 16'hffff, 16'h1234);
  endtask
  // ------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize} = {5'h00, 3'b010};
    {haddr, hwdata} = 64'h0;
    n_errors = 0;
    check_count = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_word_prog();
    t_byte();
    t_bypass();
    t_erase();
    t_hw_reset();
    chk("pin faults", 32'h0, 32'(pfbi_flash_model_i.n_bad));
    end_sim();
  end
  initial begin
    #600000;
    n_errors++;
    end_sim();
  end
endmodule
